// ==== nhc_pkg.sv ====
// ==========================================================
// Shared constants for the flash host
// ==========================================================
package nhc_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_PHASE_NS    = 20;                // Least strobe low or high time
  localparam int PHASE_CYC     = (T_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WB_NS       = 100;               // Least wait before busy is valid
  localparam int WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command bytes
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_READ_UID   = 8'hED;
  localparam logic [7:0] CMD_READ_PARAM = 8'hEC;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_READ_MODE  = 8'h00;
  localparam logic [7:0] CMD_PAGE_GO    = 8'h30;
  localparam logic [7:0] CMD_COL_SET    = 8'h05;
  localparam logic [7:0] CMD_COL_GO     = 8'hE0;

  // Address bytes and lengths
  localparam logic [7:0] ADDR_ID_STD    = 8'h00;
  localparam logic [7:0] ADDR_ID_ONFI   = 8'h20;
  localparam logic [7:0] ADDR_ZERO      = 8'h00;
  localparam int         ID_STD_LEN     = 5;
  localparam int         ID_ONFI_LEN    = 4;
  localparam int         UID_LEN        = 16;
  localparam int         PAGE_BYTES     = 2176;
  localparam int         PAGE_WORDS     = 1088;
  localparam logic [7:0] UID_XOR_OK     = 8'hFF;

  // Host operations
  typedef enum logic [3:0] {
    OP_ID_STD  = 4'h0,
    OP_ID_ONFI = 4'h1,
    OP_UID     = 4'h2,
    OP_PARAM   = 4'h3,
    OP_STATUS  = 4'h4,
    OP_RMODE   = 4'h5,
    OP_PAGE    = 4'h6,
    OP_COLUMN  = 4'h7,
    OP_DATA    = 4'h8
  } nhc_op_type;

  // Bus cycle kinds
  typedef enum logic [1:0] {
    CYC_CMD  = 2'h0,
    CYC_ADDR = 2'h1,
    CYC_READ = 2'h2
  } nhc_cyc_type;

endpackage : nhc_pkg

// ==== nhc_cyc_if.sv ====
`timescale 1ns/100ps
// ==========================================================
// One bus cycle request between sequencer and cycle engine
// ==========================================================
interface nhc_cyc_if;
  logic                 req;
  nhc_pkg::nhc_cyc_type kind;
  logic [7:0]           wbyte;
  logic                 ack;
  logic [15:0]          rword;

  modport master (output req, kind, wbyte, input ack, rword);
  modport slave  (input req, kind, wbyte, output ack, rword);
endinterface : nhc_cyc_if

// ==== nhc_cycle.sv ====
`timescale 1ns/100ps
// ==========================================================
// Cycle engine: one command, address or read cycle per request
// ==========================================================
module nhc_cycle (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  nhc_cyc_if.slave   cyc,
  output logic       o_cle,
  output logic       o_ale,
  output logic       o_we_n,
  output logic       o_re_n,
  output logic [15:0] o_io_out,
  output logic       o_io_oe,
  input  wire logic [15:0] i_io_in
);

  typedef enum logic [2:0] {
    E_IDLE = 3'h1,
    E_LOW  = 3'h2,
    E_HIGH = 3'h4
  } nhc_eng_type;

  nhc_eng_type st_q, st_d;
  logic [7:0]  div_q, div_d;
  logic        cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
  logic        oe_q, oe_d, ack_q, ack_d;
  logic [15:0] io_q, io_d, rd_q, rd_d;
  logic        tick;

  // Phase end after the least strobe time
  assign tick = (div_q == 8'(nhc_pkg::PHASE_CYC - 1));

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_d   = st_q;
    div_d  = (st_q == E_IDLE || tick) ? 8'h00 : div_q + 8'h01;
    cle_d  = cle_q;
    ale_d  = ale_q;
    we_n_d = we_n_q;
    re_n_d = re_n_q;
    oe_d   = oe_q;
    io_d   = io_q;
    rd_d   = rd_q;
    ack_d  = 1'b0;
    unique case (st_q)
      E_IDLE: begin
        if (cyc.req && !ack_q) begin
          cle_d  = (cyc.kind == nhc_pkg::CYC_CMD);
          ale_d  = (cyc.kind == nhc_pkg::CYC_ADDR);
          oe_d   = (cyc.kind != nhc_pkg::CYC_READ);
          we_n_d = (cyc.kind == nhc_pkg::CYC_READ);
          re_n_d = (cyc.kind != nhc_pkg::CYC_READ);
          io_d   = {8'h00, cyc.wbyte};   // Upper lanes zero on commands
          st_d   = E_LOW;
        end
      end
      E_LOW: begin
        if (tick) begin
          if (!re_n_q) begin
            rd_d = i_io_in;              // Sample before read strobe rises
          end
          we_n_d = 1'b1;                 // Rising write strobe latches byte
          re_n_d = 1'b1;
          st_d   = E_HIGH;
        end
      end
      E_HIGH: begin
        if (tick) begin
          cle_d = 1'b0;
          ale_d = 1'b0;
          oe_d  = 1'b0;
          ack_d = 1'b1;
          st_d  = E_IDLE;
        end
      end
      default: st_d = E_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q   <= E_IDLE;
      div_q  <= 8'h00;
      cle_q  <= 1'b0;
      ale_q  <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      oe_q   <= 1'b0;
      io_q   <= 16'h0000;
      rd_q   <= 16'h0000;
      ack_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      cle_q  <= cle_d;
      ale_q  <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      oe_q   <= oe_d;
      io_q   <= io_d;
      rd_q   <= rd_d;
      ack_q  <= ack_d;
    end
  end

  assign cyc.ack   = ack_q;
  assign cyc.rword = rd_q;
  assign o_cle     = cle_q;
  assign o_ale     = ale_q;
  assign o_we_n    = we_n_q;
  assign o_re_n    = re_n_q;
  assign o_io_out  = io_q;
  assign o_io_oe   = oe_q;

endmodule : nhc_cycle

// ==== nhc_host.sv ====
`timescale 1ns/100ps
module nhc_host #(
  parameter int DW = 8                        // 8 or 16 bit flash bus
) (
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_RESET_N,
  input  wire logic             I_OP_VALID,
  input  wire logic [3:0]       I_OP_CODE,
  input  wire logic [39:0]      I_OP_ADDR,
  input  wire logic [11:0]      I_OP_LEN,
  output logic                  O_BUSY,
  output logic                  O_DONE,
  output logic [DW-1:0]         O_RD_DATA,
  output logic                  O_RD_VALID,
  output logic                  O_UID_OK,
  output logic                  O_CE_N,
  output logic                  O_CLE,
  output logic                  O_ALE,
  output logic                  O_WE_N,
  output logic                  O_RE_N,
  output logic [15:0]           O_IO_OUT,
  output logic                  O_IO_OE,
  input  wire logic [15:0]      I_IO_IN,
  input  wire logic             I_RB_N
);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD1 = 8'h02,
    ST_ADDR = 8'h04,
    ST_CMD2 = 8'h08,
    ST_WB   = 8'h10,
    ST_RB   = 8'h20,
    ST_DATA = 8'h40,
    ST_DONE = 8'h80
  } nhc_st_type;

  nhc_cyc_if cyc ();

  nhc_st_type          st_q, st_d;
  nhc_pkg::nhc_op_type op_q, op_d;
  logic [7:0]  cmd1_q, cmd1_d, cmd2_q, cmd2_d;
  logic        has1_q, has1_d, has2_q, has2_d, wait_q, wait_d;
  logic [2:0]  naddr_q, naddr_d, asent_q, asent_d;
  logic [39:0] addr_q, addr_d;
  logic [11:0] len_q, len_d;
  logic [7:0]  wb_q, wb_d;
  logic        status_q, status_d, rctx_q, rctx_d;
  logic [4:0]  idx_q, idx_d;
  logic [7:0]  uid_mem [nhc_pkg::UID_LEN];
  logic        uid_ok_q, uid_ok_d, uid_bad;
  logic        done_q, done_d, rv_q, rv_d;
  logic [DW-1:0] rdat_q, rdat_d;
  logic        start;
  logic        busy_q;

  // Start only with the device idle and ready
  assign start = I_OP_VALID && I_RB_N;

  // ==========================================================
  // Sequencer next state
  // ==========================================================
  always_comb begin
    st_d = st_q;  op_d = op_q;  cmd1_d = cmd1_q;  cmd2_d = cmd2_q;
    has1_d = has1_q;  has2_d = has2_q;  wait_d = wait_q;  naddr_d = naddr_q;
    asent_d = asent_q;  addr_d = addr_q;  len_d = len_q;  wb_d = wb_q;
    status_d = status_q;  rctx_d = rctx_q;  done_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          op_d   = nhc_pkg::nhc_op_type'(I_OP_CODE);
          len_d  = I_OP_LEN;
          has1_d = 1'b1;  has2_d = 1'b0;  wait_d = 1'b0;
          naddr_d = 3'h0;  asent_d = 3'h0;  addr_d = I_OP_ADDR;
          wb_d = 8'h00;                    // Fresh busy wait for every operation
          cmd1_d = nhc_pkg::CMD_READ_MODE;
          cmd2_d = nhc_pkg::CMD_READ_MODE;
          unique case (nhc_pkg::nhc_op_type'(I_OP_CODE))
            nhc_pkg::OP_ID_STD: begin
              cmd1_d = nhc_pkg::CMD_READ_ID;  naddr_d = 3'h1;
              addr_d = {32'h0000_0000, nhc_pkg::ADDR_ID_STD};
            end
            nhc_pkg::OP_ID_ONFI: begin
              cmd1_d = nhc_pkg::CMD_READ_ID;  naddr_d = 3'h1;
              addr_d = {32'h0000_0000, nhc_pkg::ADDR_ID_ONFI};
            end
            nhc_pkg::OP_UID: begin
              cmd1_d = nhc_pkg::CMD_READ_UID;  naddr_d = 3'h1;  wait_d = 1'b1;
              addr_d = {32'h0000_0000, nhc_pkg::ADDR_ZERO};
            end
            nhc_pkg::OP_PARAM: begin
              cmd1_d = nhc_pkg::CMD_READ_PARAM;  naddr_d = 3'h1;  wait_d = 1'b1;
              addr_d = {32'h0000_0000, nhc_pkg::ADDR_ZERO};
            end
            nhc_pkg::OP_STATUS: cmd1_d = nhc_pkg::CMD_STATUS;
            nhc_pkg::OP_RMODE:  cmd1_d = nhc_pkg::CMD_READ_MODE;
            nhc_pkg::OP_PAGE: begin
              naddr_d = 3'h5;  has2_d = 1'b1;  wait_d = 1'b1;
              cmd2_d = nhc_pkg::CMD_PAGE_GO;
            end
            nhc_pkg::OP_COLUMN: begin
              cmd1_d = nhc_pkg::CMD_COL_SET;  naddr_d = 3'h2;  has2_d = 1'b1;
              cmd2_d = nhc_pkg::CMD_COL_GO;
            end
            // Restore data output after status polling
            default: has1_d = status_q && rctx_q;
          endcase
          st_d = (has1_d) ? ST_CMD1 : ST_DATA;
        end
      end
      ST_CMD1: if (cyc.ack) begin
        status_d = (cmd1_q == nhc_pkg::CMD_STATUS);
        if (op_q == nhc_pkg::OP_PARAM || op_q == nhc_pkg::OP_PAGE) begin
          rctx_d = 1'b1;
        end else if (op_q == nhc_pkg::OP_ID_STD || op_q == nhc_pkg::OP_ID_ONFI
                     || op_q == nhc_pkg::OP_UID) begin
          rctx_d = 1'b0;
        end
        st_d = (naddr_q != 3'h0) ? ST_ADDR : (has2_q ? ST_CMD2 : ST_DATA);
      end
      ST_ADDR: if (cyc.ack) begin
        addr_d  = {8'h00, addr_q[39:8]};   // Lowest byte goes first
        asent_d = asent_q + 3'h1;
        if (asent_d == naddr_q) begin
          st_d = has2_q ? ST_CMD2 : (wait_q ? ST_WB : ST_DATA);
        end
      end
      ST_CMD2: if (cyc.ack) begin
        wb_d = 8'h00;
        st_d = wait_q ? ST_WB : ST_DATA;
      end
      ST_WB: begin
        wb_d = wb_q + 8'h01;
        if (wb_q == 8'(nhc_pkg::WB_CYC - 1)) begin
          st_d = ST_RB;
        end
      end
      // Hold off reads until the device reports ready
      ST_RB: if (I_RB_N) begin
        st_d = ST_DATA;
      end
      ST_DATA: begin
        if (len_q == 12'h000) begin
          st_d = ST_DONE;
        end else if (cyc.ack) begin
          len_d = len_q - 12'h001;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        st_d   = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      st_q <= ST_IDLE;  op_q <= nhc_pkg::OP_ID_STD;  cmd1_q <= 8'h00;  cmd2_q <= 8'h00;
      has1_q <= 1'b0;  has2_q <= 1'b0;  wait_q <= 1'b0;  naddr_q <= 3'h0;
      asent_q <= 3'h0;  addr_q <= 40'h00_0000_0000;  len_q <= 12'h000;  wb_q <= 8'h00;
      status_q <= 1'b0;  rctx_q <= 1'b0;  done_q <= 1'b0;
    end else begin
      st_q <= st_d;  op_q <= op_d;  cmd1_q <= cmd1_d;  cmd2_q <= cmd2_d;
      has1_q <= has1_d;  has2_q <= has2_d;  wait_q <= wait_d;  naddr_q <= naddr_d;
      asent_q <= asent_d;  addr_q <= addr_d;  len_q <= len_d;  wb_q <= wb_d;
      status_q <= status_d;  rctx_q <= rctx_d;  done_q <= done_d;
    end
  end

  // ==========================================================
  // Cycle requests to the engine
  // ==========================================================
  always_comb begin
    cyc.req   = (st_q == ST_CMD1) || (st_q == ST_ADDR) || (st_q == ST_CMD2)
                || ((st_q == ST_DATA) && (len_q != 12'h000));
    cyc.kind  = (st_q == ST_ADDR) ? nhc_pkg::CYC_ADDR
              : (st_q == ST_DATA) ? nhc_pkg::CYC_READ : nhc_pkg::CYC_CMD;
    cyc.wbyte = (st_q == ST_ADDR) ? addr_q[7:0]
              : (st_q == ST_CMD2) ? cmd2_q : cmd1_q;
  end

  // ==========================================================
  // Read data and unique value check
  // ==========================================================
  assign uid_bad = idx_q[4] && ((uid_mem[idx_q[3:0]] ^ cyc.rword[7:0])
                                != nhc_pkg::UID_XOR_OK);
  always_comb begin
    rv_d     = (st_q == ST_DATA) && cyc.ack;
    rdat_d   = rv_d ? cyc.rword[DW-1:0] : rdat_q;
    idx_d    = idx_q;
    uid_ok_d = uid_ok_q;
    if (st_q == ST_IDLE && start
        && nhc_pkg::nhc_op_type'(I_OP_CODE) == nhc_pkg::OP_UID) begin
      idx_d    = 5'h00;
      uid_ok_d = 1'b1;
    end else if (rv_d && op_q == nhc_pkg::OP_UID) begin
      idx_d = idx_q + 5'h01;
      if (uid_bad) begin
        uid_ok_d = 1'b0;
      end
    end
  end

  // Data registers
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      rv_q     <= 1'b0;
      rdat_q   <= '0;
      idx_q    <= 5'h00;
      uid_ok_q <= 1'b0;
    end else begin
      rv_q     <= rv_d;
      rdat_q   <= rdat_d;
      idx_q    <= idx_d;
      uid_ok_q <= uid_ok_d;
    end
  end

  // Unique value store, first half of each pair
  always_ff @(posedge I_CLK_SYS) begin
    if (rv_d && op_q == nhc_pkg::OP_UID && !idx_q[4]) begin
      uid_mem[idx_q[3:0]] <= cyc.rword[7:0];
    end
  end

  // Chip select held low and busy held high for the whole operation
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      O_CE_N <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      O_CE_N <= (st_d == ST_IDLE);
      busy_q <= (st_d != ST_IDLE);
    end
  end

  nhc_cycle u_cycle (
    .i_clk    (I_CLK_SYS),
    .i_rst_n  (I_RESET_N),
    .cyc      (cyc.slave),
    .o_cle    (O_CLE),
    .o_ale    (O_ALE),
    .o_we_n   (O_WE_N),
    .o_re_n   (O_RE_N),
    .o_io_out (O_IO_OUT),
    .o_io_oe  (O_IO_OE),
    .i_io_in  (I_IO_IN)
  );

  assign O_BUSY     = busy_q;
  assign O_DONE     = done_q;
  assign O_RD_DATA  = rdat_q;
  assign O_RD_VALID = rv_q;
  assign O_UID_OK   = uid_ok_q;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  property p_id_idle;
    $rose(st_q == ST_CMD1) && (cmd1_q == nhc_pkg::CMD_READ_ID
      || cmd1_q == nhc_pkg::CMD_READ_UID) |-> $past(I_RB_N) && $past(st_q == ST_IDLE);
  endproperty
  a_id_idle: assert property (p_id_idle) else $error("id read started while not idle");

  property p_uid_ready;
    $rose(st_q == ST_DATA) && op_q == nhc_pkg::OP_UID
      |-> $past(st_q == ST_RB) && $past(I_RB_N);
  endproperty
  a_uid_ready: assert property (p_uid_ready) else $error("uid read before ready");

  property p_uid_check;
    rv_d && op_q == nhc_pkg::OP_UID && uid_bad |=> !O_UID_OK ##1 !O_UID_OK;
  endproperty
  a_uid_check: assert property (p_uid_check) else $error("uid mismatch not flagged");

  property p_col_seq;
    $rose(st_q == ST_CMD2) && op_q == nhc_pkg::OP_COLUMN
      |-> asent_q == 3'h2 && cyc.wbyte == nhc_pkg::CMD_COL_GO;
  endproperty
  a_col_seq: assert property (p_col_seq) else $error("column change malformed");

  property p_restore;
    (st_q == ST_DATA) && op_q == nhc_pkg::OP_DATA |-> !(status_q && rctx_q);
  endproperty
  a_restore: assert property (p_restore) else $error("data read in status mode");

  property p_page_seq;
    $rose(st_q == ST_CMD2) && op_q == nhc_pkg::OP_PAGE
      |-> asent_q == 3'h5 && cyc.wbyte == nhc_pkg::CMD_PAGE_GO ##[1:40] st_q == ST_WB;
  endproperty
  a_page_seq: assert property (p_page_seq) else $error("page read malformed");

  c_uid:  cover property ($fell(st_q == ST_DATA) && op_q == nhc_pkg::OP_UID && O_UID_OK);
  c_page: cover property ($rose(st_q == ST_RB) && op_q == nhc_pkg::OP_PAGE);
  c_rest: cover property ($rose(st_q == ST_CMD1) && op_q == nhc_pkg::OP_DATA);

endmodule : nhc_host

// ==== nhc_dev_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Behavioural flash device facing the host
// ==========================================================
module nhc_dev_model #(
  parameter logic [7:0] ID_BASE  = 8'hC1,  // Arbitrary identity byte base
  parameter logic [7:0] UID_BASE = 8'h3C   // Arbitrary unique value base
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_cle,
  input  wire logic        i_ale,
  input  wire logic        i_we_n,
  input  wire logic        i_re_n,
  input  wire logic [15:0] i_io,
  input  wire logic        i_bad_uid,
  input  wire logic [15:0] i_busy_ns,
  output logic [15:0]      o_io,
  output logic             o_rb_n
);
  logic [31:0] onfi_sig = "ONFI";
  logic [2:0]  mode     = 3'h0;   // Power-up in read mode
  logic        stat     = 1'b0;
  logic [7:0]  lc       = 8'h00;
  logic [7:0]  sub      = 8'h00;
  logic [7:0]  dout     = 8'h00;
  logic [7:0]  row      = 8'h00;
  logic [15:0] col      = 16'h0000;
  logic [7:0]  a [0:4];
  int          acnt     = 0;

  initial o_rb_n = 1'b1;

  // ==========================================================
  // Command and address latch on rising write strobe
  // ==========================================================
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle && !i_ale && i_re_n && (o_rb_n || i_io[7:0] == 8'h70)) begin
      acnt = 0;
      lc = i_io[7:0];
      stat = 1'b0;           // Any new command other than 70h leaves status output
      case (i_io[7:0])
        8'h90: mode = 3'h1;
        8'hED: mode = 3'h2;
        8'hEC: mode = 3'h3;
        8'h70: stat = 1'b1;
        8'h00: stat = 1'b0;
        8'h30: begin
          mode = 3'h4;
          col = {a[1], a[0]};
          row = a[2];
          o_rb_n = 1'b0;
        end
        8'hE0: begin
          col = {a[1], a[0]};
          stat = 1'b0;
        end
        default: ;
      endcase
    end else if (!i_ce_n && i_ale && !i_cle && i_re_n && o_rb_n) begin
      a[acnt] = i_io[7:0];
      acnt = acnt + 1;
      if (lc == 8'h90 || lc == 8'hED || lc == 8'hEC) begin
        sub = i_io[7:0];
        col = 16'h0000;
      end
      if (lc == 8'hED || lc == 8'hEC) o_rb_n = 1'b0;
    end
  end

  // Busy span of an array read
  always @(negedge o_rb_n) begin
    #(i_busy_ns);
    o_rb_n = 1'b1;
  end

  // Next word on falling read strobe
  always @(negedge i_re_n) begin
    if (!i_ce_n && !i_cle && !i_ale && i_we_n && o_rb_n && !stat) begin
      case (mode)
        3'h1: dout = (sub == 8'h20) ? onfi_sig[8*(3-col[1:0]) +: 8]
                                    : ID_BASE + col[7:0];
        3'h2: dout = !col[4] ? UID_BASE + col[3:0] :
                     (i_bad_uid ? UID_BASE + col[3:0] : ~(UID_BASE + col[3:0]));
        3'h3: dout = col[7:0] ^ 8'h5A;
        default: dout = col[7:0] ^ row;
      endcase
      col = col + 16'h0001;
    end
  end

  // Live status or data while strobes low, inverse once released
  always_comb begin
    if (!i_ce_n && !i_re_n && stat) o_io = {8'h00, 1'b1, o_rb_n, o_rb_n, 5'h00};
    else if (!i_ce_n && !i_re_n) o_io = {8'h00, dout};
    else o_io = {8'hFF, ~dout};
  end
endmodule : nhc_dev_model

// ==== nhc_host_tb_top.sv ====
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the flash host
// ==========================================================
module nhc_host_tb_top;
  localparam logic [7:0] ID_BASE  = 8'hC1;  // Arbitrary, matches model
  localparam logic [7:0] UID_BASE = 8'h3C;  // Arbitrary, matches model

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        op_valid = 1'b0;
  logic [3:0]  op_code = 4'h0;
  logic [39:0] op_addr = 40'h0;
  logic [11:0] op_len = 12'h0;
  logic        busy, done, rd_valid, uid_ok, ce_n, cle, ale, we_n, re_n, io_oe, rb_n;
  logic [7:0]  rd_data;
  logic [15:0] io_out, dev_io, io_bus;
  logic        bad_uid = 1'b0;
  logic [15:0] busy_ns = 16'h0100;
  logic [7:0]  exp [$];
  logic [31:0] onfi_sig = "ONFI";
  logic [7:0]  row;
  logic [15:0] col;
  int          seed, i, fails = 0, compares = 0;

  // Clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  // Shared bus level
  assign io_bus = io_oe ? io_out : dev_io;

  nhc_host #(.DW(8)) nhc_host_inst (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_OP_VALID(op_valid), .I_OP_CODE(op_code),
    .I_OP_ADDR(op_addr), .I_OP_LEN(op_len), .O_BUSY(busy), .O_DONE(done),
    .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_UID_OK(uid_ok), .O_CE_N(ce_n),
    .O_CLE(cle), .O_ALE(ale), .O_WE_N(we_n), .O_RE_N(re_n), .O_IO_OUT(io_out),
    .O_IO_OE(io_oe), .I_IO_IN(io_bus), .I_RB_N(rb_n));

  nhc_dev_model nhc_dev_model_inst (
    .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_io(io_out), .i_bad_uid(bad_uid), .i_busy_ns(busy_ns), .o_io(dev_io),
    .o_rb_n(rb_n));

  task automatic chk_data(input string name, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, e, s);
    end
  endtask : chk_data

  task automatic chk_flag(input string name, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %b seen %b", name, e, s);
    end
  endtask : chk_flag

  // One host operation, waits for its completion
  task automatic op(input logic [3:0] c, input logic [39:0] ad, input logic [11:0] n);
    int t;
    t = 0;
    @(posedge clk);
    op_code <= c;
    op_addr <= ad;
    op_len <= n;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    chk_flag("busy", 1'b1, busy);
    while (done !== 1'b1 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    chk_flag("done", 1'b1, done);
    chk_flag("idle", 1'b0, busy);
  endtask : op

  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Read words against oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp.size() == 0) chk_flag("extra_word", 1'b0, 1'b1);
      else chk_data("rd_data", exp.pop_front(), rd_data);
    end
  end

  // Watchdog
  initial begin
    #500000;
    fails++;
    results();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 32'h8560B456;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    exp.push_back(8'hE0);
    op(4'h4, 40'h0, 12'd1);
    for (i = 0; i < 5; i++) exp.push_back(ID_BASE + i[7:0]);
    op(4'h0, 40'h0, 12'd5);
    for (i = 0; i < 4; i++) exp.push_back(onfi_sig[8*(3-i) +: 8]);
    op(4'h1, 40'h0, 12'd4);
    busy_ns <= 16'd200 + 16'($unsigned($random(seed)) % 400);
    for (i = 0; i < 64; i++) exp.push_back(i[4] ? ~(UID_BASE + i[3:0]) : UID_BASE + i[3:0]);
    op(4'h2, 40'h0, 12'd64);
    chk_flag("uid_ok", 1'b1, uid_ok);
    bad_uid <= 1'b1;
    for (i = 0; i < 32; i++) exp.push_back(UID_BASE + i[3:0]);
    op(4'h2, 40'h0, 12'd32);
    chk_flag("uid_bad", 1'b0, uid_ok);
    bad_uid <= 1'b0;
    busy_ns <= 16'd3000;
    for (i = 0; i < 3; i++) exp.push_back(i[7:0] ^ 8'h5A);
    op(4'h3, 40'h0, 12'd3);
    for (i = 100; i < 102; i++) exp.push_back(i[7:0] ^ 8'h5A);
    op(4'h7, 40'd100, 12'd2);
    exp.push_back(8'hE0);
    op(4'h4, 40'h0, 12'd1);
    for (i = 102; i < 104; i++) exp.push_back(i[7:0] ^ 8'h5A);
    op(4'h8, 40'h0, 12'd2);
    col = 16'($unsigned($random(seed)) % 2172);
    row = 8'($random(seed));
    for (i = 0; i < 4; i++) exp.push_back((col[7:0] + i[7:0]) ^ row);
    op(4'h6, {16'h0000, row, col}, 12'd4);
    for (i = 2174; i < 2176; i++) exp.push_back(i[7:0] ^ row);
    op(4'h7, 40'd2174, 12'd2);
    for (i = 0; i < 2; i++) exp.push_back(i[7:0] ^ row);
    op(4'h7, 40'd0, 12'd2);
    exp.push_back(8'hE0);
    op(4'h4, 40'h0, 12'd1);
    for (i = 2; i < 4; i++) exp.push_back(i[7:0] ^ row);
    op(4'h5, 40'h0, 12'd2);
    repeat (20) @(posedge clk);
    chk_flag("queue_empty", 1'b1, exp.size() == 0);
    results();
  end
endmodule : nhc_host_tb_top
